// ===== inc/pmcap_defines.svh
/*
  Offsets, field positions, reset values and field encodings of the power-management capability word.
  Assumes inclusion by bare name from any file that needs them; holds definitions only.
*/
`ifndef PMCAP_DEFINES_SVH
`define PMCAP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register placement within the capability item
// ----------------------------------------------------------------------------
`define PMCAP_OFF_WORD      8'h02

// ----------------------------------------------------------------------------
// Field layout of the capability word
// ----------------------------------------------------------------------------
`define PMCAP_PME_MSB       15
`define PMCAP_PME_LSB       11
`define PMCAP_D2_BIT        10
`define PMCAP_PME_D0_BIT    0
`define PMCAP_PME_D1_BIT    1
`define PMCAP_PME_D2_BIT    2
`define PMCAP_PME_D3H_BIT   3
`define PMCAP_PME_D3C_BIT   4

// ----------------------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------------------
`define PMCAP_PME_OFF       5'h00
`define PMCAP_PME_NOAUX     5'h09
`define PMCAP_PME_AUX       5'h19
`define PMCAP_D2_VALUE      1'h0
`define PMCAP_WORD_RST      16'h0000
`define PMCAP_DATA_RST      16'h0000
`define PMCAP_LOW_ZERO      10'h000

`endif

// ===== inc/pmcap_pkg.sv
/*
  Types and the shared capability-field encoder for the power-management capability word.
  Assumes pmcap_defines.svh is on the include path.
*/
`include "pmcap_defines.svh"

package pmcap_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [15:0] pmcap_word_t;
  typedef logic [4:0]  pmcap_pme_t;

  typedef enum logic [1:0] {
    PMCAP_IDLE = 2'h0,
    PMCAP_ACK  = 2'h1
  } pmcap_state_e;

  // --------------------------------------------------------------------------
  // Capability field from the power-management enable and the aux supply
  // --------------------------------------------------------------------------
  function automatic pmcap_pme_t pmcap_pme_field(input logic pm_en, input logic aux);
    pmcap_pme_t f;
    f = `PMCAP_PME_OFF; // RULE2 RULE5
    if (pm_en && aux) begin
      f = `PMCAP_PME_AUX; // RULE4 RULE6
    end else if (pm_en) begin
      f = `PMCAP_PME_NOAUX; // RULE3 RULE6
    end
    return f;
  endfunction : pmcap_pme_field

endpackage : pmcap_pkg

// ===== hw/pmcap_word_gen.sv
/*
  Builds the capability word each cycle from the power-management enable and the aux supply level.
  Assumes both inputs are synchronous to sys_clk; the word lags them by one clock.
*/
`timescale 1ns/1ns
`include "pmcap_defines.svh"

module pmcap_word_gen (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                pm_enable,
  input  wire logic                aux_supply_present,
  output      pmcap_pkg::pmcap_word_t cap_word
);

  // --------------------------------------------------------------------------
  // Word assembly
  // --------------------------------------------------------------------------
  pmcap_pkg::pmcap_word_t next_cap_word;

  always_comb begin
    next_cap_word = `PMCAP_WORD_RST;
    // Unsupported states stay zero because the encoder only ever sets D0, D3hot, D3cold
    next_cap_word[`PMCAP_PME_MSB:`PMCAP_PME_LSB] = pmcap_pkg::pmcap_pme_field(pm_enable, aux_supply_present); // RULE1
    next_cap_word[`PMCAP_D2_BIT] = `PMCAP_D2_VALUE; // RULE7
  end

  // Tracked every cycle so a strap change shows on the next read without a reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cap_word <= `PMCAP_WORD_RST;
    end else begin
      cap_word <= next_cap_word; // RULE9
    end
  end

endmodule : pmcap_word_gen

// ===== hw/pmcap_cfg.sv
/*
  Configuration-space slave for the read-only power-management capability word.
  Assumes one configuration read or write request pulse at a time, with a new request only after
  the previous one has been acknowledged; pm_enable and aux_supply_present are synchronous levels.
*/
`timescale 1ns/1ns
`include "pmcap_defines.svh"

// Summary of operation
// RULE1 - PME capability field sits in bits 15:11
// RULE2 - States without PME support read zero
// RULE3 - Enabled management sets D0 and D3hot
// RULE4 - Enabled with aux supply adds D3cold
// RULE5 - Disabled management returns all-zero field
// RULE6 - Field is 01001 or 11001 when enabled
// RULE7 - State_d2_supported bit always reads zero
// RULE8 - Host keeps clock running unless reset
// RULE9 - Writes ignored; reads track live inputs
module pmcap_cfg (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        pm_enable,
  input  wire logic        aux_supply_present,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_off,
  input  wire logic [15:0] cfg_wdata,
  output      logic [15:0] cfg_rdata,
  output      logic        cfg_ack,
  output      logic [4:0]  pme_capable
);

  // --------------------------------------------------------------------------
  // Capability word source
  // --------------------------------------------------------------------------
  pmcap_pkg::pmcap_word_t cap_word;

  pmcap_word_gen u_word_gen (
    .sys_clk            (sys_clk),
    .nrst               (nrst),
    .pm_enable          (pm_enable),
    .aux_supply_present (aux_supply_present),
    .cap_word           (cap_word)
  );

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  pmcap_pkg::pmcap_state_e state;
  pmcap_pkg::pmcap_state_e next_state;
  logic [15:0]             next_cfg_rdata;
  logic                    next_cfg_ack;
  logic [4:0]              next_pme_capable;
  logic                    req;
  logic                    hit;

  // Write data is never stored; the word has no writable field
  logic                    wdata_unused;

  assign req          = cfg_rd | cfg_wr;
  assign hit          = (cfg_off == `PMCAP_OFF_WORD);
  assign wdata_unused = ^cfg_wdata;

  always_comb begin
    next_state       = state;
    next_cfg_rdata   = `PMCAP_DATA_RST;
    next_cfg_ack     = 1'b0;
    next_pme_capable = cap_word[`PMCAP_PME_MSB:`PMCAP_PME_LSB];
    unique case (state)
      pmcap_pkg::PMCAP_IDLE: begin
        if (req) begin
          next_state   = pmcap_pkg::PMCAP_ACK;
          next_cfg_ack = 1'b1;
          // Read of the word returns the live value; other offsets and writes return zero
          if (cfg_rd && !cfg_wr && hit) begin
            next_cfg_rdata = cap_word; // RULE9
          end
        end
      end
      pmcap_pkg::PMCAP_ACK: begin
        // Requests in this cycle are dropped; the host waits for the acknowledge
        next_state = pmcap_pkg::PMCAP_IDLE;
      end
      default: begin
        next_state = pmcap_pkg::PMCAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state       <= pmcap_pkg::PMCAP_IDLE;
      cfg_rdata   <= `PMCAP_DATA_RST;
      cfg_ack     <= 1'b0;
      pme_capable <= `PMCAP_PME_OFF;
    end else begin
      state       <= next_state;
      cfg_rdata   <= next_cfg_rdata;
      cfg_ack     <= next_cfg_ack;
      pme_capable <= next_pme_capable;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Helper: a read of the word answered this cycle, with the inputs it reflects
  logic word_read_ack;
  logic rd_hit_q;
  logic en_q2;
  logic aux_q2;
  logic en_q1;
  logic aux_q1;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_hit_q <= 1'b0;
      en_q1    <= 1'b0;
      aux_q1   <= 1'b0;
      en_q2    <= 1'b0;
      aux_q2   <= 1'b0;
    end else begin
      rd_hit_q <= (state == pmcap_pkg::PMCAP_IDLE) && cfg_rd && !cfg_wr && hit;
      en_q1    <= pm_enable;
      aux_q1   <= aux_supply_present;
      en_q2    <= en_q1;
      aux_q2   <= aux_q1;
    end
  end

  assign word_read_ack = cfg_ack && rd_hit_q;

  AST_FIELD_VALUE: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE6
    word_read_ack && en_q2 |-> cfg_rdata[`PMCAP_PME_MSB:`PMCAP_PME_LSB] == (aux_q2 ? `PMCAP_PME_AUX : `PMCAP_PME_NOAUX))
    else $error("capability field wrong with management enabled");

  AST_FIELD_POS: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE1
    word_read_ack |-> cfg_rdata[`PMCAP_PME_MSB:`PMCAP_PME_LSB] == {en_q2 & aux_q2, en_q2, 1'b0, 1'b0, en_q2}
                      && cfg_rdata[9:0] == `PMCAP_LOW_ZERO)
    else $error("capability field not in bits 15:11");

  AST_NO_D1_D2_PME: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
    word_read_ack |-> cfg_rdata[12] == 1'b0 && cfg_rdata[13] == 1'b0)
    else $error("PME reported from an unsupported state");

  // Two register stages lie between the enable pin and pme_capable
  AST_D0_D3HOT: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE3
    $past(pm_enable, 2) |-> pme_capable[`PMCAP_PME_D0_BIT] && pme_capable[`PMCAP_PME_D3H_BIT])
    else $error("D0 or D3hot PME missing while enabled");

  AST_D3COLD: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE4
    ##2 pme_capable[`PMCAP_PME_D3C_BIT] == ($past(pm_enable, 2) && $past(aux_supply_present, 2)))
    else $error("D3cold PME does not follow enable and aux supply");

  AST_DISABLED_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE5
    word_read_ack && !en_q2 |-> cfg_rdata[15:11] == 5'h00)
    else $error("capability field not zero while disabled");

  AST_D2_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE7
    cfg_ack |-> cfg_rdata[10] == 1'b0)
    else $error("State_d2_supported bit set");

  AST_WRITE_IGNORED: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE9
    (state == pmcap_pkg::PMCAP_IDLE) && cfg_wr
      |=> cfg_ack && cfg_rdata == `PMCAP_DATA_RST
      ##1 !cfg_ack && cap_word[`PMCAP_PME_MSB:`PMCAP_PME_LSB] == {en_q1 & aux_q1, en_q1, 1'b0, 1'b0, en_q1})
    else $error("write disturbed the capability word");

  AST_ACK_ONCE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == pmcap_pkg::PMCAP_IDLE) && req |=> cfg_ack ##1 !cfg_ack)
    else $error("acknowledge not a single cycle after request");

  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == pmcap_pkg::PMCAP_IDLE) && cfg_rd && !hit |=> cfg_rdata == 16'h0000)
    else $error("unmapped offset returned data");

endmodule : pmcap_cfg

// ===== bench/pmcap_host_model.sv
/*
  Host bridge model that issues configuration reads and writes to the capability word.
  Assumes the one-cycle request pulse and the single-cycle acknowledge of the config port.
*/
`timescale 1ns/1ns

module pmcap_host_model (
  input  wire logic        sys_clk,
  input  wire logic        cfg_ack,
  input  wire logic [15:0] cfg_rdata,
  output      logic        cfg_rd,
  output      logic        cfg_wr,
  output      logic [7:0]  cfg_off,
  output      logic [15:0] cfg_wdata
);
  initial begin
    cfg_rd    = 1'h0;
    cfg_wr    = 1'h0;
    cfg_off   = 8'hFF;
    cfg_wdata = 16'hFFFF;
  end

  // ----------------------------------------------------------------------------
  // One transfer: pulse, then wait a bounded time for the acknowledge
  // ----------------------------------------------------------------------------
  task automatic xfer(input logic is_wr, input logic [7:0] off, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic ok);
    ok    = 1'h0;
    rdata = 16'h0000;
    @(posedge sys_clk);
    cfg_rd    <= ~is_wr;
    cfg_wr    <= is_wr;
    cfg_off   <= off;
    cfg_wdata <= wdata;
    @(posedge sys_clk);
    cfg_rd    <= 1'h0;
    cfg_wr    <= 1'h0;
    // Released lines show the inverse so stale values cannot pass for answers
    cfg_off   <= ~off;
    cfg_wdata <= ~wdata;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      if (cfg_ack === 1'h1) begin
        ok    = 1'h1;
        rdata = cfg_rdata;
      end
    end
  endtask : xfer
endmodule : pmcap_host_model

// ===== bench/pmcap_cfg_tb_top.sv
/*
  Self-checking bench for the capability word: every enable/aux combination, ignored writes, idle data.
  Assumes pmcap_cfg and the host model are compiled ahead of it.
*/
`timescale 1ns/1ns

module pmcap_cfg_tb_top;
  logic        sys_clk;
  logic        nrst;
  logic        pm_enable;
  logic        aux_supply_present;
  logic        cfg_rd;
  logic        cfg_wr;
  logic        cfg_ack;
  logic        ok;
  logic [7:0]  cfg_off;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic [15:0] rd_val;
  logic [4:0]  pme_capable;
  logic [4:0]  exp_f;
  int          n_errors;
  int          cmp_count;

  pmcap_cfg pmcap_cfg_inst (.sys_clk(sys_clk), .nrst(nrst), .pm_enable(pm_enable),
    .aux_supply_present(aux_supply_present), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_off(cfg_off),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .pme_capable(pme_capable));

  pmcap_host_model pmcap_host_model_inst (.sys_clk(sys_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_off(cfg_off), .cfg_wdata(cfg_wdata));

  // Clock never stops, so no reset-before-stop sequence is needed
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic do_xfer(input logic is_wr, input logic [7:0] off, input logic [15:0] wdata);
    pmcap_host_model_inst.xfer(is_wr, off, wdata, rd_val, ok);
    if (ok !== 1'h1) begin
      n_errors++;
      $display("MISMATCH cfg_ack expected 1 seen 0");
      wrap_up();
    end
  endtask : do_xfer

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    nrst               = 1'h0;
    pm_enable          = 1'h0;
    aux_supply_present = 1'h0;
    n_errors           = 0;
    cmp_count          = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    // Walks disabled, disabled+aux, enabled, enabled+aux; reads must follow the live inputs
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      pm_enable          <= k[1];
      aux_supply_present <= k[0];
      repeat (3) @(posedge sys_clk);
      exp_f = (k[1] == 0) ? 5'h00 : ((k[0] == 1) ? 5'h19 : 5'h09);
      check("pme_capable", {11'h000, pme_capable}, {11'h000, exp_f});
      do_xfer(1'h0, 8'h02, 16'h0000);
      check("cap_word", rd_val, {exp_f, 1'h0, 10'h000});
      do_xfer(1'h1, 8'h02, 16'hFFFF);
      do_xfer(1'h0, 8'h02, 16'h0000);
      check("cap_word_after_write", rd_val, {exp_f, 1'h0, 10'h000});
    end
    #1;
    check("rdata_idle", cfg_rdata, 16'h0000);
    do_xfer(1'h0, 8'h00, 16'h0000);
    check("unmapped_offset", rd_val, 16'h0000);
    wrap_up();
  end
endmodule : pmcap_cfg_tb_top
